// ### hw/bmsc_pkg.sv
// Shared constants for the buck mode and slew control block.
package bmsc_pkg;
    // -------------------------------------------------------------
    // Clock and timing
    // -------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int STEP_TIME_NS = 32000;
    localparam int STEP_CYC = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BLANK_TIMEOUT_NS = 1000000;
    localparam int BLANK_TIMEOUT_CYC = (BLANK_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BLANK_SW_CYCLES = 8;
    // Ultrasonic floor limits in clock cycles, one per floor selection code.
    localparam int US_LIMIT_0 = 400;
    localparam int US_LIMIT_1 = 350;
    localparam int US_LIMIT_2 = 300;
    localparam int US_LIMIT_3 = 250;
    localparam int GAP_W = 9;
    // -------------------------------------------------------------
    // Power-save selection codes
    // -------------------------------------------------------------
    localparam logic [1:0] PSV_CCM_A = 2'h0;
    localparam logic [1:0] PSV_PSAVE = 2'h1;
    localparam logic [1:0] PSV_ULTRA = 2'h2;
    localparam logic [1:0] PSV_CCM_B = 2'h3;
    // -------------------------------------------------------------
    // Comparator bit positions
    // -------------------------------------------------------------
    localparam int CMP_W = 11;
    localparam int CMP_BELOW80 = 0;
    localparam int CMP_ABOVE90 = 1;
    localparam int CMP_ABOVE120 = 2;
    localparam int CMP_BELOW110 = 3;
    localparam int CMP_ABOVE550 = 4;
    localparam int CMP_TRIP500 = 5;
    localparam int CMP_SWHIGH = 6;
    localparam int CMP_SUPPLYOK = 7;
    localparam int CMP_LIGHT = 8;
    localparam int CMP_ZERO = 9;
    localparam int CMP_ONDONE = 10;
    // -------------------------------------------------------------
    // Reference slew state machine
    // -------------------------------------------------------------
    typedef enum logic [1:0] {
        SL_IDLE = 2'h0,
        SL_STEP = 2'h1,
        SL_BLANK = 2'h3
    } bmsc_slew_e;
endpackage : bmsc_pkg

// ### hw/bmsc_cmp_if.sv
// Interface carrying synchronised comparator levels.
`timescale 1ns/1ps
interface bmsc_cmp_if #(parameter int W = bmsc_pkg::CMP_W);
    logic [W-1:0] level;
    modport src (output level);
    modport dst (input level);
endinterface : bmsc_cmp_if

// ### hw/bmsc_sync.sv
// Two-stage synchroniser bank for comparator results.
`timescale 1ns/1ps
module bmsc_sync #(
    parameter int W = bmsc_pkg::CMP_W
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic [W-1:0] rawIn,
    bmsc_cmp_if.src cmp
);
    // -------------------------------------------------------------
    // Synchroniser stages
    // -------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_sync
            logic meta_ff;
            logic hold_ff;
            // The first stage feeds only the second stage.
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta_ff <= 1'b0;
                    hold_ff <= 1'b0;
                end else if (clkEn) begin
                    meta_ff <= rawIn[i];
                    hold_ff <= meta_ff;
                end
            end
            assign cmp.level[i] = hold_ff;
        end
    endgenerate
endmodule : bmsc_sync

// ### hw/bmsc_top.sv
// Supervisory logic of the step-down controller: gates, output-good, slewing.
//
// Summary of operation
// [RULE1] Ultrasonic code enables a light-load frequency floor chosen by floor select.
// [RULE2] Gap timer between high pulses turns low gate on at the limit.
// [RULE3] Output-good drops below 80 percent, recovers above 90 percent.
// [RULE4] Output-good held low until soft-start is complete.
// [RULE5] Output-good drops above 120 percent, recovers below 110 percent.
// [RULE6] Supply lockout stops switching and floats both gate outputs.
// [RULE7] Power-on clear resets all state and the soft-start logic.
// [RULE8] In power save, feedback above 550 mV cancels it and turns low gate on.
// [RULE9] Feedback back at 500 mV starts a normal on-time cycle.
// [RULE10] Power save resumes on the next cycle if load stays light.
// [RULE11] Reference steps toward a new target, 32 us per step.
// [RULE12] Faults blanked while slewing until 8 switching cycles after target.
// [RULE13] Slewing forces discontinuous mode, previous mode restored after blanking.
// [RULE14] Blanking ends after 1 ms even without switching cycles.
// [RULE15] Discharge pull-down used only when slewing down, never up.
// [RULE16] Slew pull-down stops once the reference reaches its target.
// [RULE17] Disabled switching turns on the output shutdown pull-down.
// [RULE18] Shutdown pull-down stays on after the enable pin goes low.
// [RULE19] No shutdown pull-down unless enable was high since power-up.
// [RULE20] High gate starts slow, goes fast once switch node is above 0.5 V.
// [RULE21] Host should leave power save or use ultrasonic before slewing down.
// [RULE22] Power-save codes 01 and 10 enable light-load power save.
// [RULE23] Codes 00 and 11 force continuous conduction at all loads.
// [RULE24] All comparator results are synchronised before use.
`timescale 1ns/1ps
module bmsc_top #(
    parameter int TIMEOUT_CYC = bmsc_pkg::BLANK_TIMEOUT_CYC,
    parameter int REF_W = 8
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic [1:0] powerSaveSelect,
    input wire logic [1:0] ultrasonicFloorSelect,
    input wire logic internalDischargeEnable,
    input wire logic [4:0] fineAdjustCode,
    input wire logic [2:0] marginCode,
    input wire logic switchEnable,
    input wire logic enablePin,
    input wire logic softStartDone,
    input wire logic [bmsc_pkg::CMP_W-1:0] cmpRaw,
    output logic highGateOut,
    output logic highGateOe,
    output logic highGateFast,
    output logic lowGateOut,
    output logic lowGateOe,
    output logic outputGoodOut,
    output logic outputGoodOe,
    output logic slewPullDown,
    output logic shutdownPullDown,
    output logic faultBlank,
    output logic discontinuousMode,
    output logic [REF_W-1:0] refLevel
);
    localparam int TO_W = $clog2(TIMEOUT_CYC + 1);
    localparam int GAP_W_L = bmsc_pkg::GAP_W;
    localparam int ST_W = $clog2(bmsc_pkg::STEP_CYC + 1);

    // -------------------------------------------------------------
    // Comparator synchronisation
    // -------------------------------------------------------------
    bmsc_cmp_if cmp ();

    // Every comparator passes two flops before any logic reads it.
    bmsc_sync #(.W(bmsc_pkg::CMP_W)) u_sync ( // [RULE24]
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .rawIn(cmpRaw),
        .cmp(cmp.src)
    );

    // -------------------------------------------------------------
    // Decoded conditions
    // -------------------------------------------------------------
    logic hiOn_ff;
    logic loOn_ff;
    logic usLo_ff;
    logic gateOe_ff;
    logic hiFast_ff;
    logic smartHold_ff;
    logic pgUv_ff;
    logic pgOv_ff;
    logic pgLow_ff;
    logic enSeen_ff;
    logic shutPd_ff;
    logic slewPd_ff;
    logic blank_ff;
    logic dcm_ff;
    logic [GAP_W_L-1:0] gapCnt_ff;
    logic [REF_W-1:0] ref_ff;
    logic [ST_W-1:0] stepCnt_ff;
    logic [3:0] swCnt_ff;
    logic [TO_W-1:0] toCnt_ff;
    logic slewDown_ff;
    bmsc_pkg::bmsc_slew_e slew_ff;
    bmsc_pkg::bmsc_slew_e nxt_slew;

    wire supplyOk = cmp.level[bmsc_pkg::CMP_SUPPLYOK];
    wire trip = cmp.level[bmsc_pkg::CMP_TRIP500];
    wire onDone = cmp.level[bmsc_pkg::CMP_ONDONE];
    wire zeroCross = cmp.level[bmsc_pkg::CMP_ZERO];
    wire lightLoad = cmp.level[bmsc_pkg::CMP_LIGHT];
    // Switching runs only with supply above lockout and switching enabled.
    wire run = supplyOk & switchEnable; // [RULE6]
    // Codes 01 and 10 allow power save; 00 and 11 stay continuous except while slewing.
    wire psEnable = (powerSaveSelect == bmsc_pkg::PSV_PSAVE)
        | (powerSaveSelect == bmsc_pkg::PSV_ULTRA); // [RULE22] [RULE23]
    // Power save comes back by itself once the leakage hold has ended.
    wire psActive = psEnable & lightLoad & ~smartHold_ff; // [RULE10]
    wire usMode = (powerSaveSelect == bmsc_pkg::PSV_ULTRA) & psActive; // [RULE1]
    wire slewBusy = (slew_ff != bmsc_pkg::SL_IDLE);
    // Discontinuous while slewing, else whatever the selection asks for.
    wire discontinuous_mode = psActive | slewBusy; // [RULE13]
    wire smartSet = run & psEnable & lightLoad & ~smartHold_ff
        & cmp.level[bmsc_pkg::CMP_ABOVE550]; // [RULE8]

    // -------------------------------------------------------------
    // Gate sequencing
    // -------------------------------------------------------------
    wire [GAP_W_L-1:0] usLimit = (ultrasonicFloorSelect == 2'h0)
        ? GAP_W_L'(bmsc_pkg::US_LIMIT_0)
        : (ultrasonicFloorSelect == 2'h1) ? GAP_W_L'(bmsc_pkg::US_LIMIT_1)
        : (ultrasonicFloorSelect == 2'h2) ? GAP_W_L'(bmsc_pkg::US_LIMIT_2)
        : GAP_W_L'(bmsc_pkg::US_LIMIT_3); // [RULE1]
    // A new on-time starts at the 500 mV trip unless leakage discharge holds.
    wire startHi = run & trip & ~hiOn_ff & ~smartHold_ff & ~smartSet; // [RULE9]
    wire endHi = hiOn_ff & onDone;
    wire usFloorHit = run & usMode & ~hiOn_ff & ~loOn_ff
        & (gapCnt_ff >= usLimit); // [RULE2]
    wire loStart = endHi | usFloorHit | smartSet;
    wire loStop = startHi | (discontinuous_mode & zeroCross & ~smartHold_ff & ~usLo_ff);
    wire nxt_lo = run & (loStart | (loOn_ff & ~loStop));
    // A leakage event cuts a running on-time so it never leaves both gates on together.
    wire nxt_hi = run & (startHi | (hiOn_ff & ~onDone & ~smartSet)); // [RULE8]
    wire nxt_fast = nxt_hi & hiOn_ff & (hiFast_ff | cmp.level[bmsc_pkg::CMP_SWHIGH]);

    // Gate drive state and the interval timer between high pulses.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hiOn_ff <= 1'b0;
            loOn_ff <= 1'b0;
            usLo_ff <= 1'b0;
            hiFast_ff <= 1'b0;
            gateOe_ff <= 1'b0;
            gapCnt_ff <= '0;
        end else if (clkEn) begin
            hiOn_ff <= nxt_hi;
            loOn_ff <= nxt_lo; // [RULE8]
            usLo_ff <= run & (usFloorHit | (usLo_ff & ~startHi));
            hiFast_ff <= nxt_fast; // [RULE20]
            gateOe_ff <= supplyOk; // [RULE6]
            if (startHi || usFloorHit) begin
                gapCnt_ff <= '0; // [RULE2]
            end else if (gapCnt_ff != '1) begin
                gapCnt_ff <= gapCnt_ff + 1'b1;
            end
        end
    end

    // Leakage hold: set above 550 mV, released at the 500 mV trip.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            smartHold_ff <= 1'b0;
        end else if (clkEn) begin
            smartHold_ff <= run & (smartSet | (smartHold_ff & ~trip)); // [RULE8] [RULE9]
        end
    end

    // -------------------------------------------------------------
    // Output-good with under- and over-voltage hysteresis
    // -------------------------------------------------------------
    wire nxt_uv = cmp.level[bmsc_pkg::CMP_BELOW80]
        | (pgUv_ff & ~cmp.level[bmsc_pkg::CMP_ABOVE90]); // [RULE3]
    wire nxt_ov = cmp.level[bmsc_pkg::CMP_ABOVE120]
        | (pgOv_ff & ~cmp.level[bmsc_pkg::CMP_BELOW110]); // [RULE5]
    wire nxt_pgLow = pgUv_ff | pgOv_ff | ~softStartDone | ~run; // [RULE4]

    // Fault flags and the open-drain pull-down of output-good.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pgUv_ff <= 1'b0;
            pgOv_ff <= 1'b0;
            pgLow_ff <= 1'b1;
        end else if (clkEn) begin
            pgUv_ff <= nxt_uv;
            pgOv_ff <= nxt_ov;
            pgLow_ff <= nxt_pgLow;
        end
    end

    // -------------------------------------------------------------
    // Shutdown pull-down
    // -------------------------------------------------------------
    // Only an enable seen high since power-up arms the pull-down.
    wire nxt_shutPd = (enSeen_ff | enablePin) & ~run; // [RULE17] [RULE19]

    // The enable memory is cleared only by power-on clear.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            enSeen_ff <= 1'b0; // [RULE7] [RULE19]
            shutPd_ff <= 1'b0;
        end else if (clkEn) begin
            enSeen_ff <= enSeen_ff | enablePin; // [RULE18]
            shutPd_ff <= nxt_shutPd;
        end
    end

    // -------------------------------------------------------------
    // Reference slewing and fault blanking
    // -------------------------------------------------------------
    wire [REF_W-1:0] target = REF_W'({marginCode, fineAdjustCode});
    wire atTarget = (ref_ff == target);
    wire stepTick = (stepCnt_ff == ST_W'(bmsc_pkg::STEP_CYC - 1));
    wire swDone = startHi & (swCnt_ff == 4'(bmsc_pkg::BLANK_SW_CYCLES - 1));
    wire toDone = (toCnt_ff == TO_W'(TIMEOUT_CYC - 1));
    wire [REF_W-1:0] nxt_ref = (target < ref_ff) ? ref_ff - 1'b1 : ref_ff + 1'b1;
    // Pull-down only while stepping downward and enabled.
    wire nxt_slewPd = internalDischargeEnable & (nxt_slew == bmsc_pkg::SL_STEP)
        & (target < (stepTick ? nxt_ref : ref_ff)); // [RULE15] [RULE16]

    // Next state of the slew sequencer.
    always_comb begin
        nxt_slew = slew_ff;
        unique case (slew_ff)
            bmsc_pkg::SL_IDLE: begin
                if (run && !atTarget) begin
                    nxt_slew = bmsc_pkg::SL_STEP; // [RULE11]
                end
            end
            bmsc_pkg::SL_STEP: begin
                if (stepTick && nxt_ref == target) begin
                    nxt_slew = bmsc_pkg::SL_BLANK; // [RULE12]
                end
            end
            bmsc_pkg::SL_BLANK: begin
                if (!atTarget) begin
                    nxt_slew = bmsc_pkg::SL_STEP;
                end else if (swDone || toDone) begin
                    nxt_slew = bmsc_pkg::SL_IDLE; // [RULE12] [RULE14]
                end
            end
            default: begin
                nxt_slew = bmsc_pkg::SL_IDLE;
            end
        endcase
        if (!run) begin
            nxt_slew = bmsc_pkg::SL_IDLE;
        end
    end

    // Reference level, step timer and blanking counters.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            slew_ff <= bmsc_pkg::SL_IDLE;
            ref_ff <= '0;
            stepCnt_ff <= '0;
            swCnt_ff <= '0;
            toCnt_ff <= '0;
        end else if (clkEn) begin
            slew_ff <= nxt_slew;
            if (!run) begin
                ref_ff <= target;
            end else if (slew_ff == bmsc_pkg::SL_STEP && stepTick) begin
                ref_ff <= nxt_ref; // [RULE11]
            end
            stepCnt_ff <= (slew_ff == bmsc_pkg::SL_STEP && !stepTick)
                ? stepCnt_ff + 1'b1 : '0;
            if (slew_ff != bmsc_pkg::SL_BLANK) begin
                swCnt_ff <= '0;
                toCnt_ff <= '0;
            end else begin
                swCnt_ff <= swCnt_ff + 4'(startHi);
                toCnt_ff <= toCnt_ff + 1'b1; // [RULE14]
            end
        end
    end

    // Registered copies of the slew outputs.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            slewPd_ff <= 1'b0;
            blank_ff <= 1'b0;
            dcm_ff <= 1'b0;
            slewDown_ff <= 1'b0;
        end else if (clkEn) begin
            slewPd_ff <= nxt_slewPd;
            blank_ff <= (nxt_slew != bmsc_pkg::SL_IDLE);
            dcm_ff <= discontinuous_mode;
            slewDown_ff <= (target < ref_ff);
        end
    end

    // -------------------------------------------------------------
    // Output assignments
    // -------------------------------------------------------------
    assign highGateOut = hiOn_ff;
    assign highGateOe = gateOe_ff;
    assign highGateFast = hiFast_ff;
    assign lowGateOut = loOn_ff;
    assign lowGateOe = gateOe_ff;
    assign outputGoodOut = 1'b0;
    assign outputGoodOe = pgLow_ff;
    assign slewPullDown = slewPd_ff;
    assign shutdownPullDown = shutPd_ff;
    assign faultBlank = blank_ff;
    assign discontinuousMode = dcm_ff;
    assign refLevel = ref_ff;

    // -------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_lockout_float: assert property ( // [RULE6]
        clkEn && !supplyOk |=> !highGateOe && !lowGateOe)
        else $error("Gates not floated under lockout.");
    a_lockout_noswitch: assert property ( // [RULE6]
        clkEn && !supplyOk |=> !highGateOut && !lowGateOut)
        else $error("Switching during lockout.");
    a_uv_pgood: assert property ( // [RULE3]
        clkEn && cmp.level[bmsc_pkg::CMP_BELOW80] ##1 clkEn |=> outputGoodOe)
        else $error("Output-good not low under 80 percent.");
    a_uv_hold: assert property ( // [RULE3]
        $fell(pgUv_ff) |-> $past(cmp.level[bmsc_pkg::CMP_ABOVE90]))
        else $error("Under-voltage cleared without 90 percent.");
    a_ov_hold: assert property ( // [RULE5]
        $fell(pgOv_ff) |-> $past(cmp.level[bmsc_pkg::CMP_BELOW110]))
        else $error("Over-voltage cleared without 110 percent.");
    a_softstart_pgood: assert property ( // [RULE4]
        clkEn && !softStartDone |=> outputGoodOe)
        else $error("Output-good released before soft-start end.");
    a_smart_lowon: assert property ( // [RULE8]
        clkEn && smartSet |=> lowGateOut && !highGateOut)
        else $error("Leakage discharge did not turn low gate on.");
    a_floor_lowon: assert property ( // [RULE2]
        clkEn && usFloorHit |=> lowGateOut)
        else $error("Frequency floor did not turn low gate on.");
    a_step_time: assert property ( // [RULE11]
        run && $past(run) && $changed(refLevel)
        |-> $past(stepCnt_ff) == ST_W'(bmsc_pkg::STEP_CYC - 1))
        else $error("Reference stepped at the wrong time.");
    a_blank_slew: assert property ( // [RULE12]
        slew_ff == bmsc_pkg::SL_STEP && clkEn && run |=> faultBlank)
        else $error("Faults not blanked while slewing.");
    a_pd_down_only: assert property ( // [RULE15]
        slewPullDown |-> $past(internalDischargeEnable) && slewDown_ff)
        else $error("Slew pull-down on when not slewing down.");
    a_dcm_slew: assert property ( // [RULE13]
        slewBusy && clkEn |=> discontinuousMode)
        else $error("Not discontinuous during slew.");
    a_shut_armed: assert property ( // [RULE19]
        shutdownPullDown |-> enSeen_ff)
        else $error("Shutdown pull-down without prior enable.");
    a_fast_drive: assert property ( // [RULE20]
        $rose(highGateOut) |-> !highGateFast)
        else $error("High gate started fast.");
endmodule : bmsc_top

// ### bench/bmsc_stage_model.sv
// Behavioural power stage: switch node, on-time end and inductor zero crossing.
`timescale 1ns/1ps
module bmsc_stage_model #(
    parameter int SW_DLY = 3,
    parameter int ON_CYC = 10,
    parameter int ZC_CYC = 6
) (
    input wire logic core_clk,
    input wire logic highGateOut,
    input wire logic highGateOe,
    input wire logic lowGateOut,
    input wire logic lowGateOe,
    output logic swHigh,
    output logic zeroCross,
    output logic onDone
);
    int hiCnt = 0;
    int loCnt = 0;
    // A floated gate drives nothing, so the stage only sees enabled drive.
    always @(posedge core_clk) begin
        hiCnt <= (highGateOut && highGateOe) ? hiCnt + 1 : 0;
        loCnt <= (lowGateOut && lowGateOe) ? loCnt + 1 : 0;
    end
    assign swHigh = (hiCnt >= SW_DLY);
    assign onDone = (hiCnt >= ON_CYC);
    assign zeroCross = (loCnt >= ZC_CYC);
endmodule : bmsc_stage_model

// ### bench/bmsc_top_test.sv
// Self-checking testbench for the supervisory block with a power stage model.
`timescale 1ns/1ps
module bmsc_top_test;
    localparam int TMO = 50;
    localparam int LIMIT_CYC = 20000;
    logic core_clk = 0;
    logic rst_n = 0;
    logic [1:0] powerSaveSelect = 2'h0;
    logic [1:0] ultrasonicFloorSelect = 2'h0;
    logic internalDischargeEnable = 0;
    logic [4:0] fineAdjustCode = 5'h10;
    logic switchEnable = 0;
    logic enablePin = 0;
    logic softStartDone = 0;
    logic [10:0] tbCmp = 11'h00A;
    logic swHigh, zeroCross, onDone, highGateOut, highGateOe, highGateFast;
    logic lowGateOut, lowGateOe, outputGoodOut, outputGoodOe, slewPullDown, shutdownPullDown;
    logic faultBlank, discontinuousMode;
    logic [7:0] refLevel;
    wire [10:0] cmpRaw = {onDone, zeroCross, tbCmp[8:7], swHigh, tbCmp[5:0]};
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    int seed = 75876;
    int n, d, lim, last, k;
    logic prevLow;
    int expQ[$];

    bmsc_top #(.TIMEOUT_CYC(TMO)) u_dut (.core_clk(core_clk), .rst_n(rst_n), .clkEn(1'b1),
        .powerSaveSelect(powerSaveSelect), .ultrasonicFloorSelect(ultrasonicFloorSelect),
        .internalDischargeEnable(internalDischargeEnable), .fineAdjustCode(fineAdjustCode),
        .marginCode(3'h0), .switchEnable(switchEnable), .enablePin(enablePin),
        .softStartDone(softStartDone), .cmpRaw(cmpRaw), .highGateOut(highGateOut),
        .highGateOe(highGateOe), .highGateFast(highGateFast), .lowGateOut(lowGateOut),
        .lowGateOe(lowGateOe), .outputGoodOut(outputGoodOut), .outputGoodOe(outputGoodOe),
        .slewPullDown(slewPullDown), .shutdownPullDown(shutdownPullDown),
        .faultBlank(faultBlank), .discontinuousMode(discontinuousMode), .refLevel(refLevel));
    bmsc_stage_model u_stage (.core_clk(core_clk), .highGateOut(highGateOut),
        .highGateOe(highGateOe), .lowGateOut(lowGateOut), .lowGateOe(lowGateOe),
        .swHigh(swHigh), .zeroCross(zeroCross), .onDone(onDone));

    initial begin
        forever #50 core_clk = ~core_clk;
    end

    task tally_and_finish;
        if (num_errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    // Inputs always move one nanosecond after the rising edge.
    task tick(input int c);
        repeat (c) @(posedge core_clk);
        #1;
    endtask : tick

    task waitHigh;
        n = 0;
        while (highGateOut !== 1'b1 && n < 12) begin
            tick(1);
            n++;
        end
    endtask : waitHigh

    // A hang is cut short and counted as a mismatch.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == LIMIT_CYC) begin
            num_errors++;
            tally_and_finish();
        end
    end

    initial begin
        tick(20);
        check("gate enables in reset", {highGateOe, lowGateOe}, 0);
        check("output good pull in reset", {outputGoodOut, outputGoodOe}, 1);
        check("reference in reset", refLevel, 0);
        rst_n = 1;
        switchEnable = 1;
        tick(5);
        check("gate enables in lockout", {highGateOe, lowGateOe}, 0);
        check("shutdown pull never enabled", shutdownPullDown, 0);
        tbCmp[7] = 1;
        enablePin = 1;
        tick(5);
        check("gate enables supply ok", {highGateOe, lowGateOe}, 3);
        check("output good during start", outputGoodOe, 1);
        softStartDone = 1;
        tick(5);
        check("output good released", outputGoodOe, 0);
        // Under-voltage then over-voltage window, each with its hysteresis.
        for (k = 0; k < 4; k += 2) begin
            tbCmp[k] = 1;
            tbCmp[k + 1] = 0;
            tick(5);
            check("output good on fault", outputGoodOe, 1);
            tbCmp[k] = 0;
            tick(5);
            check("output good in hysteresis", outputGoodOe, 1);
            tbCmp[k + 1] = 1;
            tick(5);
            check("output good recovered", outputGoodOe, 0);
        end
        powerSaveSelect = 2'h1;
        tbCmp[8] = 1;
        tbCmp[4] = 1;
        tick(5);
        check("leakage", {highGateOut, lowGateOut, discontinuousMode}, 2);
        tbCmp[4] = 0;
        tbCmp[5] = 1;
        waitHigh();
        check("cycle after leakage", highGateOut, 1);
        check("high gate slow start", highGateFast, 0);
        tbCmp[5] = 0;
        tick(6);
        check("high gate fast phase", highGateFast, 1);
        check("power save resumed", discontinuousMode, 1);
        // Let the pulse and its low phase end so the first floor is timed from a fresh start.
        tick(20);
        powerSaveSelect = 2'h2;
        for (k = 0; k < 4; k++) begin
            ultrasonicFloorSelect = k[1:0];
            lim = (k == 0) ? bmsc_pkg::US_LIMIT_0 : (k == 1) ? bmsc_pkg::US_LIMIT_1 :
                (k == 2) ? bmsc_pkg::US_LIMIT_2 : bmsc_pkg::US_LIMIT_3;
            tbCmp[5] = 1;
            waitHigh();
            tbCmp[5] = 0;
            last = 0;
            for (n = 1; n <= lim + 30; n++) begin
                prevLow = lowGateOut;
                tick(1);
                if (lowGateOut === 1'b1 && prevLow !== 1'b1) last = n;
            end
            check("floor pulse", last >= lim - 8 && last <= lim + 8, 1);
        end
        // Slews start with continuous mode selected, which the host should pick first.
        powerSaveSelect = 2'h0;
        tbCmp[8] = 0;
        internalDischargeEnable = 1;
        for (k = 0; k < 2; k++) begin
            d = 2 + ({$random(seed)} % 2);
            for (n = 1; n <= d; n++) expQ.push_back(k ? refLevel + n : refLevel - n);
            fineAdjustCode = k ? fineAdjustCode + d[4:0] : fineAdjustCode - d[4:0];
            for (int i = 1; i <= d; i++) begin
                last = refLevel;
                n = 0;
                while (refLevel === last[7:0] && n < bmsc_pkg::STEP_CYC + 20) begin
                    tick(1);
                    n++;
                end
                check("reference step", refLevel, expQ.pop_front());
                if (i > 1) check("step length", n, bmsc_pkg::STEP_CYC);
                if (i < d) begin
                    check("slew pull-down", slewPullDown, k == 0);
                    check("slew modes", {faultBlank, discontinuousMode}, 3);
                end
            end
            tick(3);
            check("pull-down at target", slewPullDown, 0);
            check("blank after target", faultBlank, 1);
            tick(TMO + 15);
            check("blank timed out", {faultBlank, discontinuousMode}, 0);
        end
        switchEnable = 0;
        tick(5);
        check("shutdown pull-down", shutdownPullDown, 1);
        enablePin = 0;
        tick(5);
        check("shutdown pull-down held", shutdownPullDown, 1);
        rst_n = 0;
        tick(2);
        rst_n = 1;
        tick(5);
        check("no pull-down after power cycle", shutdownPullDown, 0);
        tally_and_finish();
    end
endmodule : bmsc_top_test
